// File: src/ppp_pkg.sv
package ppp_pkg;
    // data type codes on the mode pins
    localparam logic [3:0] MODE_COMMAND  = 4'h0;
    localparam logic [3:0] MODE_ADDR_LO  = 4'h1;
    localparam logic [3:0] MODE_ADDR_HI  = 4'h2;
    localparam logic [3:0] MODE_DATA     = 4'h5;

    // command words
    localparam logic [15:0] CMD_READ          = 16'h0011;
    localparam logic [15:0] CMD_WRITE_PAGE    = 16'h0012;
    localparam logic [15:0] CMD_WRITE_LOCK    = 16'h0022;
    localparam logic [15:0] CMD_ERASE_WRITE   = 16'h0032;
    localparam logic [15:0] CMD_ERASE_WR_LOCK = 16'h0042;
    localparam logic [15:0] CMD_ERASE_ALL     = 16'h0013;
    localparam logic [15:0] CMD_SET_LOCK      = 16'h0014;
    localparam logic [15:0] CMD_CLEAR_LOCK    = 16'h0024;
    localparam logic [15:0] CMD_GET_LOCK      = 16'h0015;
    localparam logic [15:0] CMD_SET_NVM       = 16'h0034;
    localparam logic [15:0] CMD_CLEAR_NVM     = 16'h0044;
    localparam logic [15:0] CMD_GET_NVM       = 16'h0025;
    localparam logic [15:0] CMD_SET_SECURITY  = 16'h0054;
    localparam logic [15:0] CMD_GET_SECURITY  = 16'h0035;
    localparam logic [15:0] CMD_MEM_WRITE     = 16'h001f;
    localparam logic [15:0] CMD_GET_VERSION   = 16'h001e;

    // interface version, value is arbitrary
    localparam logic [15:0] IF_VERSION = 16'h0001;

    // array geometry (word addressed, 16-bit words)
    localparam int FLASH_AW   = 12;
    localparam int PAGE_AW    = 7;
    localparam int PAGE_NUM_W = FLASH_AW - PAGE_AW;
    localparam int RAM_AW     = 8;
    localparam logic [PAGE_AW-1:0]  PAGE_LAST  = 7'h7f;
    localparam logic [FLASH_AW-1:0] FLASH_LAST = 12'hfff;
    localparam logic [15:0]         ERASED     = 16'hffff;

    // axi4-lite register map
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_BITS   = 8'h08;
    localparam int         CTRL_EN_BIT    = 0;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [3:0] {
        PPP_IDLE, PPP_EXEC, PPP_FLUSH, PPP_ERASE, PPP_RD_OE,
        PPP_RD_DRIVE, PPP_RD_HOLD, PPP_RD_REL, PPP_CMD_HI
    } ppp_state_t;
endpackage : ppp_pkg

// File: src/ppp_port.sv
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
// How it works
// - handshake starts on strobe low only while ready; ends with strobe and ready high.
// - mode code routes data to command, low address, high address, data or nowhere.
// - sixteen-bit command words are decoded into the command set.
// - after ready drops in a read, wait for output enable low.
// - on output enable low, drive the bus, then pull valid low.
// - on output enable high, release the bus, then raise valid.
// - after valid high, wait for strobe high, then set ready.
// - a new command completes the previous one, flushing pending page data.
// - read command returns word at address buffer then increments it.
// - page write commands store a word per data write and increment address.
// - load buffer flushes before a different page and on a new command.
// - write-and-lock sets the region lock bit after the flash write.
// - erase-write erases the page before programming the buffer.
// - erase-write-lock erases, programs, then sets the region lock bit.
// - erase-all with data 0 aborts if any lock bit is set.
// - successful erase-all also clears all lock and nvm bits.
// - set/clear lock take a mask; bit n sets or clears lock bit n.
// - get-lock returns the lock mask in the next data read.
// - set-nvm activates each nvm bit whose pattern bit is set.
// - clear-nvm deactivates each nvm bit whose pattern bit is one.
// - get-nvm returns the nvm mask in the next data read.
// - set-security with data 0; afterwards every port command is refused.
// - memory write stores words at the address buffer, incrementing it.
// - get-version makes the interface version available in the next data handshake.
module ppp_port (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  mode_sel,
    input  wire logic [15:0] data_in,
    output logic      [15:0] data_out,
    output logic             data_oe,
    input  wire logic        command_strobe_n,
    input  wire logic        output_enable_n,
    output logic             data_valid_n,
    output logic             ready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int FAW = ppp_pkg::FLASH_AW;
    localparam int PAW = ppp_pkg::PAGE_AW;
    localparam int PNW = ppp_pkg::PAGE_NUM_W;

    ppp_pkg::ppp_state_t state_q;
    logic [15:0]    flash_mem [2**FAW];
    logic [15:0]    load_buf  [2**PAW];
    logic [15:0]    ram_mem   [2**ppp_pkg::RAM_AW];
    logic [3:0]     mode_q;
    logic [15:0]    word_q;
    logic [15:0]    cmd_q;
    logic [31:0]    addr_q;
    logic [PNW-1:0] buf_page_q;
    logic           dirty_q;
    logic           buf_erase_q;
    logic           buf_lock_q;
    logic           pend_store_q;
    logic [FAW-1:0] idx_q;
    logic [15:0]    locks_q;
    logic [15:0]    nvm_q;
    logic           secure_q;
    logic [15:0]    rword_q;
    logic [31:0]    ctrl_q;
    logic           port_en;
    logic           exec_data;
    logic           is_page_cmd;
    logic           is_read_cmd;
    logic           page_miss;
    logic           do_store;
    logic           do_ram;
    logic [FAW-1:0] flush_addr;
    logic           flush_blocked;

    // page number and lock region of a flash word address
    function automatic logic [PNW-1:0] page_of(input logic [31:0] a);
        return a[FAW-1:PAW];
    endfunction : page_of

    function automatic logic [3:0] region_of(input logic [PNW-1:0] p);
        return p[PNW-1:1];
    endfunction : region_of

    assign port_en = ctrl_q[ppp_pkg::CTRL_EN_BIT];

    // command class decode
    always_comb begin
        is_page_cmd = (cmd_q == ppp_pkg::CMD_WRITE_PAGE) || (cmd_q == ppp_pkg::CMD_WRITE_LOCK)
                   || (cmd_q == ppp_pkg::CMD_ERASE_WRITE)
                   || (cmd_q == ppp_pkg::CMD_ERASE_WR_LOCK);
        is_read_cmd = (cmd_q == ppp_pkg::CMD_READ) || (cmd_q == ppp_pkg::CMD_GET_LOCK)
                   || (cmd_q == ppp_pkg::CMD_GET_NVM) || (cmd_q == ppp_pkg::CMD_GET_SECURITY)
                   || (cmd_q == ppp_pkg::CMD_GET_VERSION);
    end

    // data-mode actions taken in the execute cycle
    always_comb begin
        exec_data = (state_q == ppp_pkg::PPP_EXEC) && !secure_q
                 && (mode_q == ppp_pkg::MODE_DATA);
        page_miss = dirty_q && (page_of(addr_q) != buf_page_q);
        do_store  = exec_data && is_page_cmd && !page_miss;
        do_ram    = exec_data && (cmd_q == ppp_pkg::CMD_MEM_WRITE);
        flush_addr = {buf_page_q, idx_q[PAW-1:0]};
        flush_blocked = locks_q[region_of(buf_page_q)];
    end

    // flash, load buffer and ram arrays
    always_ff @(posedge mclk) begin
        if (do_store) begin
            load_buf[addr_q[PAW-1:0]] <= word_q;
        end
        if (do_ram) begin
            ram_mem[addr_q[ppp_pkg::RAM_AW-1:0]] <= word_q;
        end
        if (state_q == ppp_pkg::PPP_FLUSH) begin
            if (!flush_blocked) begin
                // erase-write replaces the word, plain write can only clear bits
                flash_mem[flush_addr] <= buf_erase_q ? load_buf[idx_q[PAW-1:0]]
                    : (flash_mem[flush_addr] & load_buf[idx_q[PAW-1:0]]);
            end
            load_buf[idx_q[PAW-1:0]] <= ppp_pkg::ERASED;
        end
        if (state_q == ppp_pkg::PPP_ERASE) begin
            flash_mem[idx_q] <= ppp_pkg::ERASED;
            load_buf[idx_q[PAW-1:0]] <= ppp_pkg::ERASED; // no unknowns in the first flush
        end
    end

    // handshake sequencer and command execution
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q      <= ppp_pkg::PPP_IDLE;
            ready        <= 1'b0;
            data_valid_n <= 1'b1;
            data_oe      <= 1'b0;
            data_out     <= 16'h0000;
            mode_q       <= 4'h0;
            word_q       <= 16'h0000;
            cmd_q        <= 16'h0000;
            addr_q       <= 32'h0000_0000;
            buf_page_q   <= '0;
            dirty_q      <= 1'b0;
            buf_erase_q  <= 1'b0;
            buf_lock_q   <= 1'b0;
            pend_store_q <= 1'b0;
            idx_q        <= '0;
            locks_q      <= 16'h0000;
            nvm_q        <= 16'h0000;
            secure_q     <= 1'b0;
            rword_q      <= 16'h0000;
        end else begin
            unique case (state_q)
                ppp_pkg::PPP_IDLE: begin
                    ready <= port_en;
                    if (ready && port_en && !command_strobe_n) begin
                        mode_q  <= mode_sel;
                        word_q  <= data_in;
                        ready   <= 1'b0;
                        state_q <= ppp_pkg::PPP_EXEC;
                    end
                end
                ppp_pkg::PPP_EXEC: begin
                    state_q <= ppp_pkg::PPP_CMD_HI;
                    if (!secure_q) begin
                        unique case (mode_q)
                            ppp_pkg::MODE_COMMAND: begin
                                cmd_q <= word_q;
                                if (dirty_q) begin
                                    idx_q        <= '0;
                                    pend_store_q <= 1'b0;
                                    state_q      <= ppp_pkg::PPP_FLUSH;
                                end
                            end
                            ppp_pkg::MODE_ADDR_LO: addr_q[15:0]  <= word_q;
                            ppp_pkg::MODE_ADDR_HI: addr_q[31:16] <= word_q;
                            ppp_pkg::MODE_DATA: begin
                                if (is_read_cmd) begin
                                    state_q <= ppp_pkg::PPP_RD_OE;
                                end
                                unique case (cmd_q)
                                    ppp_pkg::CMD_READ: begin
                                        rword_q <= flash_mem[addr_q[FAW-1:0]];
                                        addr_q  <= addr_q + 32'h1;
                                    end
                                    ppp_pkg::CMD_GET_LOCK:     rword_q <= locks_q;
                                    ppp_pkg::CMD_GET_NVM:      rword_q <= nvm_q;
                                    ppp_pkg::CMD_GET_SECURITY: rword_q <= {15'h0000, secure_q};
                                    ppp_pkg::CMD_GET_VERSION:  rword_q <= ppp_pkg::IF_VERSION;
                                    ppp_pkg::CMD_SET_LOCK:   locks_q <= locks_q | word_q;
                                    ppp_pkg::CMD_CLEAR_LOCK: locks_q <= locks_q & ~word_q;
                                    ppp_pkg::CMD_SET_NVM:    nvm_q   <= nvm_q | word_q;
                                    ppp_pkg::CMD_CLEAR_NVM:  nvm_q   <= nvm_q & ~word_q;
                                    ppp_pkg::CMD_SET_SECURITY: secure_q <= 1'b1;
                                    ppp_pkg::CMD_MEM_WRITE:  addr_q <= addr_q + 32'h1;
                                    ppp_pkg::CMD_ERASE_ALL: begin
                                        if (locks_q == 16'h0000) begin
                                            idx_q   <= '0;
                                            state_q <= ppp_pkg::PPP_ERASE;
                                        end
                                    end
                                    default: begin
                                        if (is_page_cmd && page_miss) begin
                                            idx_q        <= '0;
                                            pend_store_q <= 1'b1;
                                            state_q      <= ppp_pkg::PPP_FLUSH;
                                        end else if (is_page_cmd) begin
                                            buf_page_q  <= page_of(addr_q);
                                            dirty_q     <= 1'b1;
                                            addr_q      <= addr_q + 32'h1;
                                            buf_erase_q <= (cmd_q == ppp_pkg::CMD_ERASE_WRITE)
                                                || (cmd_q == ppp_pkg::CMD_ERASE_WR_LOCK);
                                            buf_lock_q  <= (cmd_q == ppp_pkg::CMD_WRITE_LOCK)
                                                || (cmd_q == ppp_pkg::CMD_ERASE_WR_LOCK);
                                        end
                                    end
                                endcase
                            end
                            default: ;
                        endcase
                    end
                end
                ppp_pkg::PPP_FLUSH: begin
                    idx_q <= idx_q + FAW'(1);
                    if (idx_q[PAW-1:0] == ppp_pkg::PAGE_LAST) begin
                        dirty_q <= 1'b0;
                        if (buf_lock_q) begin
                            locks_q[region_of(buf_page_q)] <= 1'b1;
                        end
                        // a store that missed the page retries once the buffer is empty
                        state_q <= pend_store_q ? ppp_pkg::PPP_EXEC : ppp_pkg::PPP_CMD_HI;
                        pend_store_q <= 1'b0;
                    end
                end
                ppp_pkg::PPP_ERASE: begin
                    idx_q <= idx_q + FAW'(1);
                    if (idx_q == ppp_pkg::FLASH_LAST) begin
                        locks_q <= 16'h0000;
                        nvm_q   <= 16'h0000;
                        dirty_q <= 1'b0;
                        state_q <= ppp_pkg::PPP_CMD_HI;
                    end
                end
                ppp_pkg::PPP_RD_OE: begin
                    if (!output_enable_n) begin
                        data_oe  <= 1'b1;
                        data_out <= rword_q;
                        state_q  <= ppp_pkg::PPP_RD_DRIVE;
                    end
                end
                ppp_pkg::PPP_RD_DRIVE: begin
                    data_valid_n <= 1'b0;
                    state_q      <= ppp_pkg::PPP_RD_HOLD;
                end
                ppp_pkg::PPP_RD_HOLD: begin
                    if (output_enable_n) begin
                        data_oe <= 1'b0;
                        state_q <= ppp_pkg::PPP_RD_REL;
                    end
                end
                ppp_pkg::PPP_RD_REL: begin
                    data_valid_n <= 1'b1;
                    state_q      <= ppp_pkg::PPP_CMD_HI;
                end
                ppp_pkg::PPP_CMD_HI: begin
                    if (command_strobe_n) begin
                        ready   <= port_en;
                        state_q <= ppp_pkg::PPP_IDLE;
                    end
                end
            endcase
        end
    end

    // axi4-lite write channel, address and data taken together
    always_comb begin
        s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
        s_axi_wready  = s_axi_awready;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_q       <= ppp_pkg::CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ppp_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= ppp_pkg::RESP_OKAY;
                if (s_axi_awaddr == ppp_pkg::REG_CTRL) begin
                    if (s_axi_wstrb[0]) begin
                        ctrl_q[7:0] <= s_axi_wdata[7:0];
                    end
                end else if (s_axi_awaddr != ppp_pkg::REG_STATUS
                          && s_axi_awaddr != ppp_pkg::REG_BITS) begin
                    s_axi_bresp <= ppp_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= ppp_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= ppp_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    ppp_pkg::REG_CTRL:   s_axi_rdata <= {24'h000000, ctrl_q[7:0]};
                    ppp_pkg::REG_STATUS: s_axi_rdata <= {cmd_q, 12'h000, dirty_q,
                        state_q != ppp_pkg::PPP_IDLE, ready, secure_q};
                    ppp_pkg::REG_BITS:   s_axi_rdata <= {nvm_q, locks_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= ppp_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : ppp_port

// File: dv/ppp_port_assertions.sv
`timescale 1ns/10ps
module ppp_port_chk (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        command_strobe_n,
    input wire logic        output_enable_n,
    input wire logic        data_valid_n,
    input wire logic        data_oe,
    input wire logic [15:0] data_out,
    input wire logic        ready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // programmer handshake ordering and axi4-lite write response hold
    take_drop_a: assert property (ready && !command_strobe_n |=> !ready)
        else $error("ready held after a taken strobe");
    drive_cause_a: assert property ($rose(data_oe) |-> !$past(output_enable_n))
        else $error("bus driven without output enable");
    valid_after_a: assert property ($fell(data_valid_n) |-> data_oe && $past(data_oe))
        else $error("valid low before bus driven");
    valid_hold_a: assert property (!data_valid_n && !output_enable_n
        |=> !data_valid_n && $stable(data_out))
        else $error("read word not held");
    release_cause_a: assert property ($fell(data_oe) |-> $past(output_enable_n))
        else $error("bus released while enable low");
    valid_rise_a: assert property ($rose(data_valid_n) |-> !data_oe && !$past(data_oe))
        else $error("valid high before bus released");
    ready_rise_a: assert property ($rose(ready) |-> $past(command_strobe_n) && data_valid_n)
        else $error("ready set before strobe high");
    busy_drive_a: assert property (data_oe |-> !ready)
        else $error("bus driven while ready");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    cover property ($fell(data_valid_n));
    cover property ($rose(ready));
    cover property (s_axi_bvalid && s_axi_bready);
endmodule : ppp_port_chk
bind ppp_port ppp_port_chk chk_u (.*);

// File: dv/ppp_prog_model.sv
`timescale 1ns/10ps
module ppp_prog_model (
    input  wire logic        mclk,
    input  wire logic        ready,
    input  wire logic        data_valid_n,
    input  wire logic [15:0] data_out,
    input  wire logic        data_oe,
    output logic      [3:0]  mode_sel,
    output logic      [15:0] data_in,
    output logic             command_strobe_n,
    output logic             output_enable_n
);
    logic [3:0]  m_q;
    logic [15:0] d_q;
    logic        drv_q;
    // pulled-up bus: programmer, device or pull-up
    assign data_in  = drv_q ? d_q : (data_oe ? data_out : 16'hffff);
    assign mode_sel = drv_q ? m_q : 4'hf;
    initial begin
        m_q = 4'h0;
        d_q = 16'h0;
        drv_q = 1'b0;
        command_strobe_n = 1'b1;
        output_enable_n = 1'b1;
    end
    // write handshake
    task automatic wr(input logic [3:0] m, input logic [15:0] d);
        @(posedge mclk iff ready === 1'b1);
        m_q <= m;
        d_q <= d;
        drv_q <= 1'b1;
        command_strobe_n <= 1'b0;
        @(posedge mclk iff ready === 1'b0);
        drv_q <= 1'b0;
        command_strobe_n <= 1'b1;
        @(posedge mclk iff ready === 1'b1);
    endtask : wr
    // read handshake, word taken while valid low
    task automatic rd(output logic [15:0] d);
        @(posedge mclk iff ready === 1'b1);
        m_q <= ppp_pkg::MODE_DATA;
        drv_q <= 1'b1;
        command_strobe_n <= 1'b0;
        @(posedge mclk iff ready === 1'b0);
        drv_q <= 1'b0;
        @(posedge mclk);
        output_enable_n <= 1'b0;
        @(posedge mclk iff data_valid_n === 1'b0);
        d = data_in;
        output_enable_n <= 1'b1;
        @(posedge mclk iff data_valid_n === 1'b1);
        drv_q <= 1'b1;
        command_strobe_n <= 1'b1;
        @(posedge mclk iff ready === 1'b1);
    endtask : rd
endmodule : ppp_prog_model

// File: dv/parallel_flash_programming_port_tb.sv
`timescale 1ns/10ps
module parallel_flash_programming_port_tb;
    logic mclk, rst, ready, data_oe, data_valid_n, command_strobe_n, output_enable_n;
    logic [3:0] mode_sel, s_axi_wstrb;
    logic [15:0] data_in, data_out, v;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, r32;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_count = 0;
    int checked = 0;
    ppp_port dut_u (.*);
    ppp_prog_model prog_u (.*);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up;
        if (err_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    // axi4-lite master cycles
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        @(posedge mclk iff (s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        @(posedge mclk);
        s_axi_bready <= 1'b1;
        @(posedge mclk iff s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(posedge mclk iff s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        @(posedge mclk iff s_axi_rvalid);
        r32 = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic cmd(input logic [15:0] c);
        prog_u.wr(ppp_pkg::MODE_COMMAND, c);
    endtask : cmd
    task automatic dw(input logic [15:0] d);
        prog_u.wr(ppp_pkg::MODE_DATA, d);
    endtask : dw
    task automatic adr(input logic [15:0] a);
        prog_u.wr(ppp_pkg::MODE_ADDR_LO, a);
        prog_u.wr(ppp_pkg::MODE_ADDR_HI, 16'h0000);
    endtask : adr
    task automatic rdw(input logic [15:0] e);
        prog_u.rd(v);
        chk(32'(v), 32'(e));
    endtask : rdw
    initial begin
        #400000;
        err_count++;
        wrap_up();
    end
    // register checks, then flash command sequences
    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        axi_rd(ppp_pkg::REG_CTRL);
        chk(r32, ppp_pkg::CTRL_RESET);
        axi_rd(8'h40);
        chk(32'(rs), 32'(ppp_pkg::RESP_SLVERR));
        axi_wr(ppp_pkg::REG_STATUS, 32'h0);
        chk(32'(rs), 32'(ppp_pkg::RESP_OKAY));
        axi_wr(ppp_pkg::REG_CTRL, 32'h0);
        repeat (3) @(posedge mclk);
        chk(32'(ready), 32'h0);
        axi_wr(ppp_pkg::REG_CTRL, 32'h1);
        cmd(ppp_pkg::CMD_ERASE_ALL);
        dw(16'h0000);
        cmd(ppp_pkg::CMD_READ);
        adr(16'h0010);
        rdw(ppp_pkg::ERASED);
        cmd(ppp_pkg::CMD_WRITE_PAGE);
        adr(16'h007f);
        dw(16'ha5a5);
        dw(16'h1234);
        cmd(ppp_pkg::CMD_READ);
        adr(16'h007f);
        rdw(16'ha5a5);
        rdw(16'h1234);
        cmd(ppp_pkg::CMD_MEM_WRITE);
        adr(16'h007d);
        dw(16'h5555);
        dw(16'h6666);
        cmd(ppp_pkg::CMD_READ);
        rdw(16'ha5a5);
        cmd(ppp_pkg::CMD_ERASE_WRITE);
        adr(16'h007f);
        dw(16'h00ff);
        cmd(ppp_pkg::CMD_READ);
        adr(16'h007f);
        rdw(16'h00ff);
        cmd(ppp_pkg::CMD_SET_LOCK);
        dw(16'h0001);
        cmd(ppp_pkg::CMD_GET_LOCK);
        rdw(16'h0001);
        cmd(ppp_pkg::CMD_ERASE_ALL);
        dw(16'h0000);
        cmd(ppp_pkg::CMD_READ);
        adr(16'h007f);
        rdw(16'h00ff);
        cmd(ppp_pkg::CMD_CLEAR_LOCK);
        dw(16'h0001);
        cmd(ppp_pkg::CMD_GET_LOCK);
        rdw(16'h0000);
        cmd(ppp_pkg::CMD_SET_NVM);
        dw(16'h0005);
        cmd(ppp_pkg::CMD_CLEAR_NVM);
        dw(16'h0001);
        cmd(ppp_pkg::CMD_GET_NVM);
        rdw(16'h0004);
        cmd(ppp_pkg::CMD_WRITE_LOCK);
        adr(16'h0090);
        dw(16'h1111);
        cmd(ppp_pkg::CMD_GET_LOCK);
        rdw(16'h0001);
        cmd(ppp_pkg::CMD_READ);
        adr(16'h0090);
        rdw(16'h1111);
        cmd(ppp_pkg::CMD_ERASE_WR_LOCK);
        adr(16'h0110);
        dw(16'h2222);
        cmd(ppp_pkg::CMD_GET_LOCK);
        rdw(16'h0003);
        cmd(ppp_pkg::CMD_CLEAR_LOCK);
        dw(16'h0003);
        cmd(ppp_pkg::CMD_ERASE_ALL);
        dw(16'h0000);
        axi_rd(ppp_pkg::REG_BITS);
        chk(r32, 32'h0);
        cmd(ppp_pkg::CMD_GET_VERSION);
        prog_u.wr(4'h7, ppp_pkg::CMD_READ);
        rdw(ppp_pkg::IF_VERSION);
        cmd(ppp_pkg::CMD_GET_SECURITY);
        rdw(16'h0000);
        cmd(ppp_pkg::CMD_SET_SECURITY);
        dw(16'h0000);
        cmd(ppp_pkg::CMD_SET_LOCK);
        dw(16'h0001);
        axi_rd(ppp_pkg::REG_BITS);
        chk(r32, 32'h0);
        cmd(ppp_pkg::CMD_ERASE_ALL);
        dw(16'h0000);
        axi_rd(ppp_pkg::REG_STATUS);
        chk(32'(r32[0]), 32'h1);
        wrap_up();
    end
endmodule : parallel_flash_programming_port_tb
